// *** clk_seq_top.sv ***
`timescale 1ns/100ps
module clk_seq_top #(
	parameter int CNT_W = 16,
	parameter int TOUT_LONG_CYC = clk_seq_pkg::TOUT_LONG,
	parameter int START_16K_CYC = clk_seq_pkg::START_16K,
	parameter int START_32K_CYC = clk_seq_pkg::START_32K
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic RESET_SOURCE_ACTIVE,
	input wire logic WDT_OSC_TICK,
	input wire logic SEL_OSC_TICK,
	input wire logic WAKE_EVENT,
	input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSES,
	input wire logic [1:0] STARTUP_TIME_FUSES,
	input wire logic DIVIDE_BY_EIGHT_FUSE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic INT_RESET_N,
	output logic SYS_CLK_EN,
	output logic [2:0] SOURCE_KIND,
	output logic CORE_CLOCK_EN,
	output logic PERIPHERAL_CLOCK_EN,
	output logic PROGRAM_MEMORY_CLOCK_EN,
	output logic ASYNC_TIMER_CLOCK_EN,
	output logic CONVERTER_CLOCK_EN,
	output logic TWO_WIRE_ADDR_EN
);
	clk_seq_pkg::fuse_type fuse_reg, fuse_next;
	clk_seq_pkg::seq_state_type state_reg, state_next;
	clk_seq_pkg::gate_type gate_reg, gate_next;
	clk_seq_pkg::src_kind_type kind;
	logic [2:0] mode_reg, mode_next;
	logic [2:0] sleep_mode_reg, sleep_mode_next;
	logic [2:0] div_reg, div_next;
	logic [2:0] kind_reg;
	logic int_rst_n_reg, int_rst_n_next;
	logic sys_en_reg, sys_en_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [CNT_W-1:0] tout_sel, start_sel, load_val;
	logic [CNT_W-1:0] seen_reg, seen_next;
	logic cnt_load, cnt_tick, cnt_done;
	logic apb_commit, sleep_go, deep_mode;

	// source decode; codes are as read with programmed bits at zero.
	function automatic clk_seq_pkg::src_kind_type decode_kind(input logic [3:0] src);
		if (src >= clk_seq_pkg::SRC_LOWPOW_MIN) begin
			decode_kind = clk_seq_pkg::KIND_LOWPOW;
		end else if (src >= clk_seq_pkg::SRC_FULLSWING_MIN) begin
			decode_kind = clk_seq_pkg::KIND_FULLSWING;
		end else if (src >= clk_seq_pkg::SRC_LOWFREQ_MIN) begin
			decode_kind = clk_seq_pkg::KIND_LOWFREQ;
		end else if (src == clk_seq_pkg::SRC_RC_128K) begin
			decode_kind = clk_seq_pkg::KIND_RC128;
		end else if (src == clk_seq_pkg::SRC_EXT) begin
			decode_kind = clk_seq_pkg::KIND_EXT;
		end else begin
			// The reserved code falls back to the calibrated RC oscillator.
			decode_kind = clk_seq_pkg::KIND_RCCAL;
		end
	endfunction

	// time-out choice; a fixed count with no supply sensing.
	function automatic logic [CNT_W-1:0] timeout_count(input clk_seq_pkg::src_kind_type k, input logic [3:0] src,
		input logic [1:0] startup_time_fuses);
		logic [2:0] idx;
		idx = {src[0], startup_time_fuses};
		timeout_count = CNT_W'(TOUT_LONG_CYC);
		if (k == clk_seq_pkg::KIND_LOWPOW || k == clk_seq_pkg::KIND_FULLSWING) begin
			case (idx % 3'h3)
				3'h0: timeout_count = CNT_W'(clk_seq_pkg::TOUT_SHORT);
				3'h2: timeout_count = '0;
				default: timeout_count = CNT_W'(TOUT_LONG_CYC);
			endcase
		end else begin
			case (startup_time_fuses)
				2'h0: timeout_count = '0;
				2'h1: timeout_count = CNT_W'(clk_seq_pkg::TOUT_SHORT);
				default: timeout_count = CNT_W'(TOUT_LONG_CYC);
			endcase
		end
	endfunction

	function automatic logic [CNT_W-1:0] startup_count(input clk_seq_pkg::src_kind_type k, input logic [3:0] src,
		input logic [1:0] startup_time_fuses);
		logic [2:0] idx;
		idx = {src[0], startup_time_fuses};
		case (k)
			clk_seq_pkg::KIND_LOWPOW, clk_seq_pkg::KIND_FULLSWING: begin
				if (idx < 3'h2) begin
					startup_count = CNT_W'(clk_seq_pkg::START_258);
				end else if (idx < 3'h5) begin
					startup_count = CNT_W'(clk_seq_pkg::START_1K);
				end else begin
					startup_count = CNT_W'(START_16K_CYC);
				end
			end
			clk_seq_pkg::KIND_LOWFREQ: startup_count = CNT_W'(START_32K_CYC);
			default: startup_count = CNT_W'(clk_seq_pkg::START_EXT);
		endcase
	endfunction

	// fuses follow the pins only while another reset source holds reset.
	always_comb begin
		fuse_next = fuse_reg;
		if (RESET_SOURCE_ACTIVE) begin
			fuse_next = '{src: CLOCK_SOURCE_SELECT_FUSES, startup_time_fuses: STARTUP_TIME_FUSES, div8: DIVIDE_BY_EIGHT_FUSE};
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			// shipped configuration until the fuses are sampled.
			fuse_reg <= '{src: clk_seq_pkg::DEF_SRC, startup_time_fuses: clk_seq_pkg::DEF_SUT, div8: clk_seq_pkg::DEF_DIV8};
		end else if (CE) begin
			fuse_reg <= fuse_next;
		end
	end

	assign kind = decode_kind(fuse_reg.src);
	assign tout_sel = timeout_count(kind, fuse_reg.src, fuse_reg.startup_time_fuses);
	assign start_sel = startup_count(kind, fuse_reg.src, fuse_reg.startup_time_fuses);
	assign deep_mode = (sleep_mode_reg == clk_seq_pkg::MODE_POWER_DOWN) ||
		(sleep_mode_reg == clk_seq_pkg::MODE_POWER_SAVE);
	assign apb_commit = PSEL && PENABLE && pready_reg;
	assign sleep_go = apb_commit && PWRITE && (PADDR == clk_seq_pkg::SLEEP_CTRL_OFS) &&
		PWDATA[clk_seq_pkg::SLEEP_GO_BIT];

	// start-up sequencer holding the internal reset.
	always_comb begin
		state_next = state_reg;
		sleep_mode_next = sleep_mode_reg;
		case (state_reg)
			clk_seq_pkg::ST_HOLD: begin
				if (!RESET_SOURCE_ACTIVE) begin
					state_next = (tout_sel == '0) ? clk_seq_pkg::ST_STARTUP : clk_seq_pkg::ST_TIMEOUT;
				end
			end
			clk_seq_pkg::ST_TIMEOUT: begin
				if (cnt_done) begin
					state_next = clk_seq_pkg::ST_STARTUP;
				end
			end
			clk_seq_pkg::ST_STARTUP: begin
				if (cnt_done) begin
					state_next = clk_seq_pkg::ST_RUN;
				end
			end
			clk_seq_pkg::ST_RUN: begin
				if (sleep_go) begin
					state_next = clk_seq_pkg::ST_SLEEP;
					sleep_mode_next = mode_reg;
				end
			end
			// deep sleep wake repeats only the start-up count.
			clk_seq_pkg::ST_SLEEP: begin
				if (WAKE_EVENT) begin
					state_next = deep_mode ? clk_seq_pkg::ST_STARTUP : clk_seq_pkg::ST_RUN;
				end
			end
			default: state_next = clk_seq_pkg::ST_HOLD;
		endcase
		if (RESET_SOURCE_ACTIVE) begin
			state_next = clk_seq_pkg::ST_HOLD;
		end
	end

	assign cnt_load = (state_next == clk_seq_pkg::ST_TIMEOUT && state_reg != clk_seq_pkg::ST_TIMEOUT) ||
		(state_next == clk_seq_pkg::ST_STARTUP && state_reg != clk_seq_pkg::ST_STARTUP);
	assign load_val = (state_next == clk_seq_pkg::ST_STARTUP) ? start_sel : tout_sel;
	assign cnt_tick = (state_reg == clk_seq_pkg::ST_TIMEOUT) ? WDT_OSC_TICK : SEL_OSC_TICK;

	tick_counter #(.W(CNT_W)) phase_cnt (
		.clk(SYS_CLK),
		.nrst(NRST),
		.ce(CE),
		.load(cnt_load),
		.load_val(load_val),
		.tick(cnt_tick),
		.done(cnt_done)
	);

	// each sleep mode leaves only the domains it needs.
	always_comb begin
		gate_next = '0;
		int_rst_n_next = (state_next == clk_seq_pkg::ST_RUN) || (state_next == clk_seq_pkg::ST_SLEEP);
		if (state_next == clk_seq_pkg::ST_RUN) begin
			gate_next = '1;
		end else if (state_next == clk_seq_pkg::ST_SLEEP) begin
			// address recognition survives every sleep mode.
			gate_next.two_wire = 1'b1;
			gate_next.async_tmr = (sleep_mode_next != clk_seq_pkg::MODE_POWER_DOWN) &&
				(sleep_mode_next != clk_seq_pkg::MODE_STANDBY);
			case (sleep_mode_next)
				clk_seq_pkg::MODE_IDLE: begin
					gate_next.periph = 1'b1;
					gate_next.conv = 1'b1;
				end
				// converter runs with core and peripherals halted.
				clk_seq_pkg::MODE_CONV_NOISE: gate_next.conv = 1'b1;
				default: gate_next.conv = 1'b0;
			endcase
		end
		// core halted in every state but run; program memory follows it.
		gate_next.progmem = gate_next.core;
	end

	// Divide-by-eight applies when its fuse is programmed, read as zero.
	always_comb begin
		div_next = div_reg;
		sys_en_next = 1'b0;
		if (SEL_OSC_TICK && int_rst_n_reg) begin
			div_next = div_reg + 3'h1;
			sys_en_next = fuse_reg.div8 || (div_reg == clk_seq_pkg::DIV8_LAST);
		end
	end

	always_comb begin
		seen_next = seen_reg;
		if (cnt_load) begin
			seen_next = '0;
		end else if (cnt_tick && !cnt_done) begin
			seen_next = seen_reg + 1'b1;
		end
	end

	always_comb begin
		pready_next = PSEL && PENABLE && !pready_reg;
		pslverr_next = 1'b0;
		prdata_next = '0;
		mode_next = mode_reg;
		if (pready_next) begin
			case (PADDR)
				clk_seq_pkg::SLEEP_CTRL_OFS: prdata_next[clk_seq_pkg::SLEEP_MODE_LSB +: 3] = mode_reg;
				clk_seq_pkg::STATUS_OFS: begin
					prdata_next[clk_seq_pkg::ST_STATE_LSB +: 3] = state_reg;
					prdata_next[clk_seq_pkg::ST_KIND_LSB +: 3] = kind_reg;
					prdata_next[clk_seq_pkg::ST_SRC_LSB +: 4] = fuse_reg.src;
					prdata_next[clk_seq_pkg::ST_SUT_LSB +: 2] = fuse_reg.startup_time_fuses;
					prdata_next[clk_seq_pkg::ST_DIV8_BIT] = fuse_reg.div8;
				end
				default: pslverr_next = 1'b1;
			endcase
		end
		if (apb_commit && PWRITE && PADDR == clk_seq_pkg::SLEEP_CTRL_OFS) begin
			mode_next = PWDATA[clk_seq_pkg::SLEEP_MODE_LSB +: 3];
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= clk_seq_pkg::ST_HOLD;
			sleep_mode_reg <= clk_seq_pkg::MODE_IDLE;
			mode_reg <= clk_seq_pkg::MODE_IDLE;
			gate_reg <= '0;
			int_rst_n_reg <= 1'b0;
			kind_reg <= 3'h0;
			div_reg <= 3'h0;
			sys_en_reg <= 1'b0;
			seen_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else if (CE) begin
			state_reg <= state_next;
			sleep_mode_reg <= sleep_mode_next;
			mode_reg <= mode_next;
			gate_reg <= gate_next;
			int_rst_n_reg <= int_rst_n_next;
			kind_reg <= kind;
			div_reg <= div_next;
			sys_en_reg <= sys_en_next;
			seen_reg <= seen_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign INT_RESET_N = int_rst_n_reg;
	assign SYS_CLK_EN = sys_en_reg;
	assign SOURCE_KIND = kind_reg;
	assign CORE_CLOCK_EN = gate_reg.core;
	assign PERIPHERAL_CLOCK_EN = gate_reg.periph;
	assign PROGRAM_MEMORY_CLOCK_EN = gate_reg.progmem;
	assign ASYNC_TIMER_CLOCK_EN = gate_reg.async_tmr;
	assign CONVERTER_CLOCK_EN = gate_reg.conv;
	assign TWO_WIRE_ADDR_EN = gate_reg.two_wire;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);

	hold_in_reset_a: assert property (CE && RESET_SOURCE_ACTIVE
		|=> !INT_RESET_N ##0 state_reg == clk_seq_pkg::ST_HOLD)
		else $error("Internal reset released while another source is active");
	timeout_len_a: assert property (CE && state_reg == clk_seq_pkg::ST_TIMEOUT
		&& state_next == clk_seq_pkg::ST_STARTUP
		|-> seen_reg == tout_sel) else $error("Time-out left after wrong count");
	startup_len_a: assert property (CE && state_reg == clk_seq_pkg::ST_STARTUP && state_next == clk_seq_pkg::ST_RUN
		|-> seen_reg == start_sel ##1 INT_RESET_N) else $error("Start-up count wrong or reset not released");
	deep_wake_a: assert property (CE && state_reg == clk_seq_pkg::ST_SLEEP && deep_mode && WAKE_EVENT
		&& !RESET_SOURCE_ACTIVE |=> state_reg == clk_seq_pkg::ST_STARTUP && !INT_RESET_N)
		else $error("Deep sleep wake skipped start-up");
	core_gate_a: assert property (CE && state_next != clk_seq_pkg::ST_RUN |=> !CORE_CLOCK_EN)
		else $error("Core clock running outside run state");
	progmem_follow_a: assert property (PROGRAM_MEMORY_CLOCK_EN == CORE_CLOCK_EN)
		else $error("Program memory clock differs from core clock");
	two_wire_a: assert property (CE && state_next == clk_seq_pkg::ST_SLEEP |=> TWO_WIRE_ADDR_EN)
		else $error("Two-wire recognition lost in sleep");
	async_sleep_a: assert property (CE && state_next == clk_seq_pkg::ST_SLEEP
		&& sleep_mode_next == clk_seq_pkg::MODE_POWER_SAVE |=> ASYNC_TIMER_CLOCK_EN && !PERIPHERAL_CLOCK_EN)
		else $error("Asynchronous timer halted in power-save");
	conv_noise_a: assert property (CE && state_next == clk_seq_pkg::ST_SLEEP
		&& sleep_mode_next == clk_seq_pkg::MODE_CONV_NOISE |=> CONVERTER_CLOCK_EN && !PERIPHERAL_CLOCK_EN)
		else $error("Converter domain wrong in noise-reduction sleep");
	fuse_hold_a: assert property (!RESET_SOURCE_ACTIVE |=> $stable(fuse_reg))
		else $error("Fuse values changed during operation");

	boot_run_c: cover property (state_reg == clk_seq_pkg::ST_TIMEOUT ##[1:1000] state_reg == clk_seq_pkg::ST_RUN);
	deep_wake_c: cover property (state_reg == clk_seq_pkg::ST_SLEEP && deep_mode ##1
		state_reg == clk_seq_pkg::ST_STARTUP);
	idle_wake_c: cover property (state_reg == clk_seq_pkg::ST_SLEEP && !deep_mode ##1 state_reg == clk_seq_pkg::ST_RUN);
endmodule

// *** clk_seq_pkg.sv ***
package clk_seq_pkg;
	localparam logic [7:0] SLEEP_CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int SLEEP_MODE_LSB = 0;
	localparam int SLEEP_GO_BIT = 8;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_KIND_LSB = 4;
	localparam int ST_SRC_LSB = 8;
	localparam int ST_SUT_LSB = 12;
	localparam int ST_DIV8_BIT = 16;
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_CONV_NOISE = 3'h1;
	localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
	localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	localparam logic [3:0] SRC_EXT = 4'h0;
	localparam logic [3:0] SRC_RSVD = 4'h1;
	localparam logic [3:0] SRC_RC_CAL = 4'h2;
	localparam logic [3:0] SRC_RC_128K = 4'h3;
	localparam logic [3:0] SRC_LOWFREQ_MIN = 4'h4;
	localparam logic [3:0] SRC_FULLSWING_MIN = 4'h6;
	localparam logic [3:0] SRC_LOWPOW_MIN = 4'h8;
	localparam logic [3:0] DEF_SRC = 4'h2;
	localparam logic [1:0] DEF_SUT = 2'h2;
	localparam logic DEF_DIV8 = 1'b0;
	localparam int TOUT_SHORT = 512;
	localparam int TOUT_LONG = 8192;
	localparam int START_EXT = 6;
	localparam int START_258 = 258;
	localparam int START_1K = 1024;
	localparam int START_16K = 16384;
	localparam int START_32K = 32768;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	typedef enum logic [2:0] {KIND_LOWPOW, KIND_FULLSWING, KIND_LOWFREQ, KIND_RC128, KIND_RCCAL, KIND_EXT}
		src_kind_type;
	typedef enum logic [2:0] {ST_HOLD, ST_TIMEOUT, ST_STARTUP, ST_RUN, ST_SLEEP} seq_state_type;
	typedef struct packed {
		logic [3:0] src;
		logic [1:0] startup_time_fuses;
		logic div8;
	} fuse_type;
	typedef struct packed {
		logic core;
		logic periph;
		logic progmem;
		logic async_tmr;
		logic conv;
		logic two_wire;
	} gate_type;
endpackage

// *** tick_counter.sv ***
`timescale 1ns/100ps
module tick_counter #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic tick,
	output logic done
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (load) begin
			count_next = load_val;
		end else if (tick && count_reg != '0) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else if (ce) begin
			count_reg <= count_next;
		end
	end

	// Done must not look at load: load is derived from the next state, which itself depends on done.
	assign done = (count_reg == '0);
endmodule

// *** osc_model.sv ***
`timescale 1ns/100ps
module osc_model #(
	parameter int PERIOD = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	output logic tick
);
	int cnt;
	// free-running oscillator cycles
	// The oscillator runs on whether or not anyone counts it; slow doubles the period.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			tick <= 1'b0;
		end else begin
			cnt <= (cnt >= (slow ? 2 * PERIOD : PERIOD) - 1) ? 0 : cnt + 1;
			tick <= (cnt == 0);
		end
	end
endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	localparam int TL = 20;
	localparam int S16 = 30;
	localparam int S32 = 40;
	logic clk, nrst, rsa, wdt_t, sel_t, wake, div, slow, psel, pen, pwr, pready, pslverr, irn, sce, e, ce;
	logic [3:0] src;
	logic [1:0] startup_time_fuses;
	logic [2:0] kind;
	logic [5:0] en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd, r;
	int miscompares, n_tests, n;
	logic [5:0] gate_tab [8] = '{6'h17, 6'h07, 6'h01, 6'h05, 6'h05, 6'h05, 6'h01, 6'h05};

	clk_seq_top #(.TOUT_LONG_CYC(TL), .START_16K_CYC(S16), .START_32K_CYC(S32)) clk_seq_top_inst (
		.SYS_CLK(clk), .NRST(nrst), .CE(ce), .RESET_SOURCE_ACTIVE(rsa), .WDT_OSC_TICK(wdt_t),
		.SEL_OSC_TICK(sel_t), .WAKE_EVENT(wake), .CLOCK_SOURCE_SELECT_FUSES(src), .STARTUP_TIME_FUSES(startup_time_fuses),
		.DIVIDE_BY_EIGHT_FUSE(div), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .INT_RESET_N(irn), .SYS_CLK_EN(sce),
		.SOURCE_KIND(kind), .CORE_CLOCK_EN(en[5]), .PERIPHERAL_CLOCK_EN(en[4]), .PROGRAM_MEMORY_CLOCK_EN(en[3]),
		.ASYNC_TIMER_CLOCK_EN(en[2]), .CONVERTER_CLOCK_EN(en[1]), .TWO_WIRE_ADDR_EN(en[0]));
	osc_model #(.PERIOD(3)) wdt_osc_inst (.clk(clk), .nrst(nrst), .slow(1'b0), .tick(wdt_t));
	osc_model #(.PERIOD(2)) sel_osc_inst (.clk(clk), .nrst(nrst), .slow(slow), .tick(sel_t));

	function automatic int n_tout(input logic [3:0] s, input logic [1:0] u);
		int i;
		i = {s[0], u};
		if (s >= 4'h6)
			return (i % 3 == 0) ? 512 : (i % 3 == 1) ? TL : 0;
		return (u == 2'h0) ? 0 : (u == 2'h1) ? 512 : TL;
	endfunction
	function automatic int n_start(input logic [3:0] s, input logic [1:0] u);
		int i;
		i = {s[0], u};
		if (s >= 4'h6)
			return (i < 2) ? 258 : (i < 5) ? 1024 : S16;
		return (s[3:1] == 3'h2) ? S32 : 6;
	endfunction
	function automatic logic [2:0] kind_of(input logic [3:0] s);
		return (s >= 4'h8) ? 3'h0 : (s >= 4'h6) ? 3'h1 : (s >= 4'h4) ? 3'h2 : (s == 4'h3) ? 3'h3 : (s == 4'h0) ? 3'h5 : 3'h4;
	endfunction
	function automatic logic [6:0] fz(input logic [31:0] v);
		return {v[clk_seq_pkg::ST_DIV8_BIT], v[clk_seq_pkg::ST_SUT_LSB +: 2], v[clk_seq_pkg::ST_SRC_LSB +: 4]};
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		cyc(1);
		pen <= 1'b1;
		cyc(1);
		while (pready !== 1'b1 && k < 20) begin
			cyc(1);
			k++;
		end
		if (pready !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t bus answer timed out", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		cyc(1);
	endtask
	task automatic boot(input logic [3:0] s, input logic [1:0] u, input logic d, input logic sl);
		int k, ex, p;
		logic bad;
		p = sl ? 4 : 2;
		ex = 3 * n_tout(s, u) + p * n_start(s, u);
		k = 0;
		bad = 1'b0;
		src <= s;
		startup_time_fuses <= u;
		div <= d;
		slow <= sl;
		rsa <= 1'b1;
		cyc(3);
		rsa <= 1'b0;
		chk(irn === 1'b0, "internal reset not held");
		while (irn !== 1'b1 && k < 9000) begin
			cyc(1);
			k++;
			if (sce === 1'b1 && irn === 1'b0)
				bad = 1'b1;
		end
		chk(k >= ex - 8 && k <= ex + 2 * p + 8, "start-up length");
		chk(!bad, "system clock during reset");
		chk(kind === kind_of(s), "source kind");
		$display("boot src %h sut %h done after %0d cycles", s, u, k);
	endtask
	task automatic count_en(input int want);
		int c;
		c = 0;
		repeat (200) begin
			cyc(1);
			c += (sce === 1'b1);
		end
		chk(c >= want - 2 && c <= want + 2, "system clock rate");
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		rsa = 1'b0;
		wake = 1'b0;
		src = 4'h0;
		startup_time_fuses = 2'h0;
		div = 1'b1;
		slow = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rnd = 32'h239A;
		cyc(3);
		nrst <= 1'b1;
		cyc(1);
		apb(1'b0, clk_seq_pkg::STATUS_OFS, 32'h0);
		chk(fz(r) === 7'h22 && e === 1'b0, "shipped fuse values");
		apb(1'b0, 8'h08, 32'h0);
		chk(e === 1'b1 && r === 32'h0, "unmapped address");
		apb(1'b1, clk_seq_pkg::STATUS_OFS, 32'hFFFF_FFFF);
		chk(e === 1'b0, "status write refused");
		$display("register test done");
		boot(4'h2, 2'h2, 1'b0, 1'b0);
		count_en(12);
		src <= 4'hF;
		startup_time_fuses <= 2'h0;
		div <= 1'b1;
		cyc(2);
		apb(1'b0, clk_seq_pkg::STATUS_OFS, 32'h0);
		chk(fz(r) === 7'h22, "fuses held in run");
		for (int s = 0; s < 16; s++)
			boot(s[3:0], s[1:0] + s[3:2], 1'b1, 1'b0);
		count_en(100);
		// With the clock enable low a reset source must not reach the sequencer.
		ce <= 1'b0;
		rsa <= 1'b1;
		cyc(3);
		rsa <= 1'b0;
		cyc(1);
		chk(irn === 1'b1 && en === 6'h3F, "clock enable freeze");
		ce <= 1'b1;
		cyc(1);
		$display("clock enable test done");
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			boot(rnd[3:0], rnd[5:4], 1'b1, 1'b1);
		end
		boot(4'h0, 2'h1, 1'b1, 1'b0);
		for (int m = 0; m < 8; m++) begin
			rnd = lfsr(rnd);
			apb(1'b1, clk_seq_pkg::SLEEP_CTRL_OFS, {rnd[31:9], 1'b0, 5'h0, m[2:0]});
			apb(1'b0, clk_seq_pkg::SLEEP_CTRL_OFS, 32'h0);
			chk(r === {29'h0, m[2:0]} && e === 1'b0, "mode readback");
			apb(1'b1, clk_seq_pkg::SLEEP_CTRL_OFS, {rnd[31:9], 1'b1, 5'h0, m[2:0]});
			chk(en === gate_tab[m], "sleep gating");
			wake <= 1'b1;
			n = 0;
			cyc(2);
			if (m == 2 || m == 3) begin
				chk(irn === 1'b0, "deep wake reset");
				while (irn !== 1'b1 && n < 200) begin
					cyc(1);
					n++;
				end
				chk(n >= 6 && n <= 24, "deep wake start-up only");
			end
			// wake level held to start-up end
			wake <= 1'b0;
			cyc(2);
			chk(en === 6'h3F, "run gating");
		end
		$display("sleep test done");
		end_of_test();
	end
endmodule
